// [include/ipr_pkg.sv]
package ipr_pkg;

  // ----------------------------------------
  // Register map (word aligned byte addresses)
  // ----------------------------------------
  localparam logic [3:0] IPR_CLOCK_CAL_OFF = 4'h0;
  localparam logic [3:0] IPR_CRC_SER_OFF = 4'h4;
  localparam logic [3:0] IPR_LOW_VOLT_OFF = 4'h8;
  localparam logic [3:0] IPR_LEVEL_OFF = 4'hc;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int IPR_CLOCK_CAL_POS = 8;
  localparam int IPR_CRC_POS = 12;
  localparam int IPR_SER2_POS = 8;
  localparam int IPR_SER1_POS = 4;
  localparam int IPR_LOW_VOLT_POS = 0;

  // ----------------------------------------
  // Reset value and level encoding
  // ----------------------------------------
  localparam logic [2:0] IPR_LEVEL_RESET = 3'h4;
  localparam logic [2:0] IPR_LEVEL_OFF_CODE = 3'h0;
  localparam logic [1:0] IPR_RESP_OKAY = 2'h0;
  localparam logic [1:0] IPR_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] clock_calendar_irq_level;
    logic [2:0] checksum_error_irq_level;
    logic [2:0] serial2_error_irq_level;
    logic [2:0] serial1_error_irq_level;
    logic [2:0] low_voltage_irq_level;
  } ipr_levels_t;

  typedef struct packed {
    logic clock_calendar;
    logic checksum_error;
    logic serial2_error;
    logic serial1_error;
    logic low_voltage;
  } ipr_enables_t;

endpackage

// [core/ipr_priority_regs.sv]
// Notes on behaviour
// - The clock/calendar level is a writable three-bit field in bits 10 to 8 of its register.
// - Code 111 is level 7, the highest, down to 001 which is level 1.
// - Code 000 disables a source so it is never offered for service.
// - Bits 15 to 11 of the clock/calendar register read zero and ignore writes.
// - Bits 7 to 0 of the clock/calendar register read zero.
`timescale 1ns/100ps
`default_nettype none
module ipr_priority_regs
  import ipr_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output ipr_levels_t o_levels,
  output ipr_enables_t o_enables
);

  // ----------------------------------------
  // Write channel capture
  // ----------------------------------------
  logic aw_held_reg;
  logic [3:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;

  assign o_awready = !aw_held_reg && !o_bvalid;
  assign o_wready = !w_held_reg && !o_bvalid;
  assign do_write = aw_held_reg && w_held_reg;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end else if (i_awvalid && o_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= i_awaddr;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end else if (i_wvalid && o_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= i_wdata;
      w_strb_reg <= i_wstrb;
    end
  end

  // ----------------------------------------
  // Write response
  // ----------------------------------------
  // Unmapped words answer with an error, not silence
  function automatic logic addr_mapped(input logic [3:0] a);
    addr_mapped = (a == IPR_CLOCK_CAL_OFF) || (a == IPR_CRC_SER_OFF) ||
                  (a == IPR_LOW_VOLT_OFF) || (a == IPR_LEVEL_OFF);
  endfunction

  function automatic logic [2:0] merge_field(input logic [2:0] old,
      input logic [2:0] nv, input logic lane);
    merge_field = lane ? nv : old;
  endfunction

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= IPR_RESP_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp <= addr_mapped(aw_addr_reg) ? IPR_RESP_OKAY : IPR_RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Level fields
  // ----------------------------------------
  // Only the field bits are stored; every other bit has no storage and reads zero, apart from the enable bits 4 to 0 of the word at 0xc.
  logic [2:0] cc_level_reg;
  logic [2:0] crc_level_reg;
  logic [2:0] ser2_level_reg;
  logic [2:0] ser1_level_reg;
  logic [2:0] lv_level_reg;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cc_level_reg <= IPR_LEVEL_RESET;
    end else if (do_write && aw_addr_reg == IPR_CLOCK_CAL_OFF) begin
      cc_level_reg <= merge_field(cc_level_reg,
          w_data_reg[IPR_CLOCK_CAL_POS +: 3], w_strb_reg[1]);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      crc_level_reg <= IPR_LEVEL_RESET;
      ser2_level_reg <= IPR_LEVEL_RESET;
      ser1_level_reg <= IPR_LEVEL_RESET;
    end else if (do_write && aw_addr_reg == IPR_CRC_SER_OFF) begin
      crc_level_reg <= merge_field(crc_level_reg, w_data_reg[IPR_CRC_POS +: 3], w_strb_reg[1]);
      ser2_level_reg <= merge_field(ser2_level_reg, w_data_reg[IPR_SER2_POS +: 3],
          w_strb_reg[1]);
      ser1_level_reg <= merge_field(ser1_level_reg, w_data_reg[IPR_SER1_POS +: 3],
          w_strb_reg[0]);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      lv_level_reg <= IPR_LEVEL_RESET;
    end else if (do_write && aw_addr_reg == IPR_LOW_VOLT_OFF) begin
      lv_level_reg <= merge_field(lv_level_reg, w_data_reg[IPR_LOW_VOLT_POS +: 3],
          w_strb_reg[0]);
    end
  end

  // ----------------------------------------
  // Outputs to arbitration
  // ----------------------------------------
  // Code passes straight through as the level: 7 highest, 1 lowest
  assign o_levels = '{cc_level_reg, crc_level_reg, ser2_level_reg, ser1_level_reg,
      lv_level_reg};

  function automatic logic level_on(input logic [2:0] lvl);
    level_on = (lvl != IPR_LEVEL_OFF_CODE);
  endfunction

  assign o_enables = '{level_on(cc_level_reg), level_on(crc_level_reg),
      level_on(ser2_level_reg), level_on(ser1_level_reg), level_on(lv_level_reg)};

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0;
    case (i_araddr)
      IPR_CLOCK_CAL_OFF: rd_word[IPR_CLOCK_CAL_POS +: 3] = cc_level_reg;
      IPR_CRC_SER_OFF: begin
        rd_word[IPR_CRC_POS +: 3] = crc_level_reg;
        rd_word[IPR_SER2_POS +: 3] = ser2_level_reg;
        rd_word[IPR_SER1_POS +: 3] = ser1_level_reg;
      end
      IPR_LOW_VOLT_OFF: rd_word[IPR_LOW_VOLT_POS +: 3] = lv_level_reg;
      IPR_LEVEL_OFF: rd_word[4:0] = o_enables;
      default: rd_word = 32'h0;
    endcase
  end

  assign o_arready = !o_rvalid;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= IPR_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_word;
      o_rresp <= addr_mapped(i_araddr) ? IPR_RESP_OKAY : IPR_RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  chk_reset_level: assert property ($past(i_sys_rst) |->
      cc_level_reg == IPR_LEVEL_RESET && crc_level_reg == IPR_LEVEL_RESET &&
      ser2_level_reg == IPR_LEVEL_RESET && ser1_level_reg == IPR_LEVEL_RESET &&
      lv_level_reg == IPR_LEVEL_RESET)
    else $error("level field not at reset value");

  chk_cc_write: assert property (do_write && aw_addr_reg == IPR_CLOCK_CAL_OFF &&
      w_strb_reg[1] |=> cc_level_reg == $past(w_data_reg[10:8]))
    else $error("clock calendar level not written");

  chk_cc_upper_zero: assert property (i_arvalid && o_arready &&
      i_araddr == IPR_CLOCK_CAL_OFF |=> o_rdata[31:11] == 21'h0)
    else $error("clock calendar upper bits not zero");

  chk_cc_low_zero: assert property (i_arvalid && o_arready &&
      i_araddr == IPR_CLOCK_CAL_OFF |=> o_rdata[7:0] == 8'h0 &&
      o_rdata[10:8] == $past(cc_level_reg))
    else $error("clock calendar read wrong");

  chk_level_pass: assert property (do_write && aw_addr_reg == IPR_LOW_VOLT_OFF &&
      w_strb_reg[0] |=> o_levels.low_voltage_irq_level == $past(w_data_reg[2:0]))
    else $error("level output not the field code");

  chk_disable_code: assert property ((cc_level_reg == 3'h0) ==
      !o_enables.clock_calendar && (lv_level_reg == 3'h0) == !o_enables.low_voltage)
    else $error("enable does not follow zero code");

  chk_bresp_one: assert property (do_write |=> o_bvalid)
    else $error("write response missing");

  chk_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");

  // ----------------------------------------
  // Field, lane and handshake checks
  // ----------------------------------------
  // A strobe wired to the wrong byte shows up in the lane checks

  chk_crc_write: assert property (do_write && aw_addr_reg == IPR_CRC_SER_OFF &&
      w_strb_reg[1] |=> crc_level_reg == $past(w_data_reg[14:12]))
    else $error("checksum error level not written");

  chk_ser2_write: assert property (do_write && aw_addr_reg == IPR_CRC_SER_OFF &&
      w_strb_reg[1] |=> ser2_level_reg == $past(w_data_reg[10:8]))
    else $error("serial2 error level not written");

  chk_ser1_write: assert property (do_write && aw_addr_reg == IPR_CRC_SER_OFF &&
      w_strb_reg[0] |=> ser1_level_reg == $past(w_data_reg[6:4]))
    else $error("serial1 error level not written");

  chk_lane_hold_hi: assert property (do_write && !w_strb_reg[1] |=>
      $stable(cc_level_reg) && $stable(crc_level_reg) && $stable(ser2_level_reg))
    else $error("upper lane field changed without strobe");

  chk_lane_hold_lo: assert property (do_write && !w_strb_reg[0] |=>
      $stable(ser1_level_reg) && $stable(lv_level_reg))
    else $error("lower lane field changed without strobe");

  chk_cc_other_addr: assert property (do_write && aw_addr_reg != IPR_CLOCK_CAL_OFF |=>
      $stable(cc_level_reg))
    else $error("clock calendar level changed by other register");

  chk_wr_unmapped: assert property (do_write && !addr_mapped(aw_addr_reg) |=>
      o_bresp == IPR_RESP_SLVERR && $stable(o_levels))
    else $error("unmapped write not refused");

  chk_wr_okay: assert property (do_write && addr_mapped(aw_addr_reg) |=>
      o_bresp == IPR_RESP_OKAY)
    else $error("mapped write answered with error");

  chk_bresp_timing: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=>
      ##1 o_bvalid)
    else $error("write response late");

  chk_bvalid_hold: assert property (o_bvalid && !i_bready |=>
      o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");

  chk_one_write: assert property (o_bvalid |->
      !aw_held_reg && !w_held_reg)
    else $error("new write taken during response");

  chk_rd_answer: assert property (i_arvalid && o_arready |=>
      o_rvalid)
    else $error("read answer missing");

  chk_rd_unmapped: assert property (i_arvalid && o_arready && !addr_mapped(i_araddr) |=>
      o_rresp == IPR_RESP_SLVERR && o_rdata == 32'h0)
    else $error("unmapped read not refused");

  chk_enable_word: assert property (i_arvalid && o_arready &&
      i_araddr == IPR_LEVEL_OFF |=> o_rdata == {27'h0, $past(o_enables)})
    else $error("enable status word wrong");

  chk_crc_spare_zero: assert property (i_arvalid && o_arready &&
      i_araddr == IPR_CRC_SER_OFF |=> o_rdata[31:15] == 17'h0 && o_rdata[11] == 1'b0 &&
      o_rdata[7] == 1'b0 && o_rdata[3:0] == 4'h0)
    else $error("shared register spare bits not zero");

  chk_lv_spare_zero: assert property (i_arvalid && o_arready &&
      i_araddr == IPR_LOW_VOLT_OFF |=> o_rdata[31:3] == 29'h0)
    else $error("low voltage spare bits not zero");

  chk_reset_bus: assert property ($past(i_sys_rst) |->
      !o_bvalid && !o_rvalid && o_enables == 5'h1f)
    else $error("bus or enables wrong after reset");

  cov_cc_write: cover property (do_write && aw_addr_reg == IPR_CLOCK_CAL_OFF);
  cov_disable: cover property (cc_level_reg == 3'h0);
  cov_top_level: cover property (crc_level_reg == 3'h7);
  cov_bad_addr: cover property (o_rvalid && o_rresp == IPR_RESP_SLVERR);
  cov_lane_split: cover property (do_write && w_strb_reg[1] != w_strb_reg[0]);

endmodule // ipr_priority_regs
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ipr_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd_d;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  ipr_levels_t levels;
  ipr_enables_t enables;
  int n_fail = 0;
  int checks_done = 0;
  logic [2:0] cv;

  ipr_priority_regs uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_levels(levels), .o_enables(enables));

  initial begin
    forever #25 i_mclk = ~i_mclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Only the four word addresses hold a register; others answer with an error
  function automatic logic [31:0] resp_of(input logic [3:0] a);
    return (a[1:0] == 2'h0) ? 32'(IPR_RESP_OKAY) : 32'(IPR_RESP_SLVERR);
  endfunction

  // Bounded waits only: a stuck handshake ends the run
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    chk("bresp", resp_of(a), 32'(bresp));
    @(posedge i_mclk);
    if (n >= 50) begin n_fail++; finish_test(); end
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    d = rdata;
    rready <= 1'b0;
    chk("rresp", resp_of(a), 32'(rresp));
    @(posedge i_mclk);
    if (n >= 50) begin n_fail++; finish_test(); end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] exp [4] = '{32'h400, 32'h4440, 32'h4, 32'h1f};
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), rd_d);
      chk("reset word", exp[i], rd_d);
    end
    chk("reset levels", 32'h4924, 32'(levels));
    $display("test reset done");
  endtask

  task automatic t_clock_field();
    wr(IPR_CLOCK_CAL_OFF, 32'hffffffff);
    rd(IPR_CLOCK_CAL_OFF, rd_d);
    chk("clock word", 32'h700, rd_d);
    chk("clock level", 32'h7, 32'(levels.clock_calendar_irq_level));
    wr(IPR_CLOCK_CAL_OFF, 32'h0);
    chk("clock enable", 32'h0, 32'(enables.clock_calendar));
    rd(IPR_LEVEL_OFF, rd_d);
    chk("enable word", 32'h0f, rd_d);
    wr(IPR_CLOCK_CAL_OFF, 32'h400);
    $display("test clock field done");
  endtask

  // Every code through the shared fields, reserved bits written as ones
  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      cv = 3'(c);
      wr(IPR_LOW_VOLT_OFF, {29'h1fffffff, cv});
      rd(IPR_LOW_VOLT_OFF, rd_d);
      chk("low voltage word", {29'h0, cv}, rd_d);
      wr(IPR_CRC_SER_OFF, {16'hffff, 1'b1, cv, 1'b1, cv, 1'b1, cv, 4'hf});
      rd(IPR_CRC_SER_OFF, rd_d);
      chk("crc serial word", {17'h0, cv, 1'b0, cv, 1'b0, cv, 4'h0}, rd_d);
      chk("levels", 32'({3'h4, cv, cv, cv, cv}), 32'(levels));
      chk("enables", 32'({1'b1, {4{cv != 3'h0}}}), 32'(enables));
    end
    $display("test codes done");
  endtask

  // Byte lanes, unmapped words and a reset in mid-run
  task automatic t_bus();
    wr(IPR_CRC_SER_OFF, 32'h0, 4'h1);
    rd(IPR_CRC_SER_OFF, rd_d);
    chk("low lane word", 32'h7700, rd_d);
    wr(IPR_CRC_SER_OFF, 32'h0, 4'h2);
    rd(IPR_CRC_SER_OFF, rd_d);
    chk("high lane word", 32'h0, rd_d);
    chk("lane enables", 32'h11, 32'(enables));
    wr(IPR_CLOCK_CAL_OFF, 32'hffffffff, 4'hd);
    rd(IPR_CLOCK_CAL_OFF, rd_d);
    chk("clock word kept", 32'h400, rd_d);
    wr(4'h2, 32'hffffffff);
    rd(4'h2, rd_d);
    chk("unmapped word", 32'h0, rd_d);
    chk("levels kept", 32'({3'h4, 3'h0, 3'h0, 3'h0, 3'h7}), 32'(levels));
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    t_reset();
    $display("test bus done");
  endtask

  initial begin
    repeat (20) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    t_reset();
    t_clock_field();
    t_codes();
    t_bus();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
